// >>> hdl/ivp_params.svh
// Constants for the interrupt vectoring and priority block
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

`define IVP_VEC_W 7
`define IVP_LVL_W 5
`define IVP_ADDR_W 32
`define IVP_NMI_VEC 7'h0B
`define IVP_UBRK_VEC 7'h0C
`define IVP_DBG_VEC 7'h0D
`define IVP_NMI_LVL 5'h10
`define IVP_UBRK_LVL 5'h0F
`define IVP_DBG_LVL 5'h0F
`define IVP_PIN_VEC_BASE 7'h40
`define IVP_ENC_VEC_BASE 7'h40
`define IVP_VEC_SHIFT 2
`define IVP_PRIO_C_RST 16'h0000
`define IVP_ETH_SRC_N 19
`define IVP_MAC_SRC_N 3
`define IVP_MAC_SUM_BIT 5'h00
`define IVP_ETH_SRC_IDX 0

`endif

// >>> hdl/ivp_pkg.sv
// Types shared by the interrupt vectoring and priority block
package ivp_pkg;

  typedef enum logic [1:0] {
    IVP_MODE_ENCODED = 2'b00,
    IVP_MODE_PINS = 2'b01
  } ivp_mode_e;

  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [6:0] vector;
    logic ext;
  } ivp_req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [6:0] vector;
    logic [31:0] table_addr;
  } ivp_grant_s;

endpackage

// >>> hdl/ivp_prio_pick.sv
// Highest-level picker with fixed index order among equal levels
`timescale 1ns/10ps
module ivp_prio_pick #(
  parameter int N = 8,
  parameter int IW = (N > 1) ? $clog2(N) : 1
) (
  input wire logic [N-1:0] req,
  input wire logic [N*4-1:0] lvl,
  output logic hit,
  output logic [IW-1:0] idx,
  output logic [3:0] level
);

  always_comb begin
    hit = 1'b0;
    idx = '0;
    level = 4'h0;
    // Scan downward with >= so the lowest index wins a tie
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && lvl[i*4 +: 4] != 4'h0 &&
          (!hit || lvl[i*4 +: 4] >= level)) begin
        hit = 1'b1;
        idx = IW'(i);
        level = lvl[i*4 +: 4];
      end
    end
  end

endmodule

// >>> hdl/ivp_ctrl.sv
// Interrupt vectoring and priority resolution, IRQ mode
`timescale 1ns/10ps
`include "ivp_params.svh"

// Notes on behaviour
// - The table address is the vector base plus four times the vector.
// - External requests may take their vector from an external fetch.
// - Each peripheral delivers its own software-set 7-bit vector.
// - Mode select picks encoded levels 1-15 or four separate pins.
// - The Ethernet event is the OR of 19 enabled status sources.
// - Three MAC status bits feed the summary bit, up to 22 sources.
// - Equal levels are served in a fixed order, highest first.
module ivp_ctrl
  import ivp_pkg::*;
#(
  parameter int NPER = 16,
  parameter int PIN_N = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nmi_req,
  input wire logic user_break_req,
  input wire logic debug_interface_req,
  input wire logic external_input_mode_select,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic [PIN_N-1:0] external_request_pins,
  input wire logic prio_c_we,
  input wire logic [15:0] prio_c_wdata,
  input wire logic ext_vector_fetch_en,
  input wire logic [6:0] ext_vector,
  input wire logic [NPER-1:0] periph_req,
  input wire logic [NPER*4-1:0] periph_level,
  input wire logic [NPER*7-1:0] vector_number_reg,
  input wire logic [18:0] eth_dma_status_reg,
  input wire logic [18:0] eth_dma_status_enable_reg,
  input wire logic [2:0] mac_status_reg,
  input wire logic [2:0] mac_status_enable,
  input wire logic [31:0] vector_base_register,
  input wire logic [3:0] core_mask_level,
  output logic irq_valid_q,
  output logic [4:0] irq_level_q,
  output logic [6:0] irq_vector_q,
  output logic [31:0] irq_table_addr_q,
  output logic ethernet_dma_event_q,
  output logic [15:0] priority_level_reg_c_q
);

  localparam int PIW = (NPER > 1) ? $clog2(NPER) : 1;

  ivp_grant_s grant_d;
  ivp_grant_s grant_q;
  logic [15:0] prio_c_d;
  logic [15:0] prio_c_q;
  logic eth_event_d;
  logic eth_event_q;
  logic [18:0] eth_status_eff;
  logic mac_status_summary_bit;
  logic [NPER-1:0] per_req_eff;
  logic per_hit;
  logic [PIW-1:0] per_idx;
  logic [3:0] per_level;
  ivp_req_s fixed_req;
  ivp_req_s ext_req;
  ivp_req_s per_sel;
  ivp_req_s win;
  ivp_mode_e mode;

  // Selects one 7-bit vector field out of the packed vector array
  function automatic logic [6:0] vec_field(
    input logic [NPER*7-1:0] vecs,
    input logic [PIW-1:0] i
  );
    vec_field = vecs[i*7 +: 7];
  endfunction

  // Accepted vector is turned into its table address
  function automatic logic [31:0] table_addr(
    input logic [31:0] base,
    input logic [6:0] vec
  );
    table_addr = base + {23'h000000, vec, 2'b00};
  endfunction

  // Keeps the winner unless the challenger has a strictly higher level
  function automatic ivp_req_s prefer(
    input ivp_req_s a,
    input ivp_req_s b
  );
    if (!a.valid) begin
      prefer = b;
    end else if (b.valid && b.level > a.level) begin
      prefer = b;
    end else begin
      prefer = a;
    end
  endfunction

  // Ethernet summary: MAC status folds into one status bit
  always_comb begin
    mac_status_summary_bit = |(mac_status_reg & mac_status_enable);
    eth_status_eff = eth_dma_status_reg;
    eth_status_eff[`IVP_MAC_SUM_BIT] =
      eth_dma_status_reg[`IVP_MAC_SUM_BIT] | mac_status_summary_bit;
    eth_event_d = |(eth_status_eff & eth_dma_status_enable_reg);
  end

  // Ethernet event rides on peripheral slot 0, the highest default order
  always_comb begin
    per_req_eff = periph_req;
    per_req_eff[`IVP_ETH_SRC_IDX] = eth_event_q;
  end

  // Peripheral slots map one to one; slot 0 takes the Ethernet event, not periph_req[0]
  ivp_prio_pick #(
    .N(NPER),
    .IW(PIW)
  ) u_per_pick (
    .req(per_req_eff),
    .lvl(periph_level),
    .hit(per_hit),
    .idx(per_idx),
    .level(per_level)
  );

  // Priority field register for the external requests
  always_comb begin
    prio_c_d = prio_c_q;
    if (prio_c_we) begin
      prio_c_d = prio_c_wdata;
    end
  end

  // Fixed-vector sources, NMI first
  always_comb begin
    fixed_req = '0;
    if (nmi_req) begin
      fixed_req.valid = 1'b1;
      fixed_req.level = `IVP_NMI_LVL;
      fixed_req.vector = `IVP_NMI_VEC;
    end else if (user_break_req) begin
      fixed_req.valid = 1'b1;
      fixed_req.level = `IVP_UBRK_LVL;
      fixed_req.vector = `IVP_UBRK_VEC;
    end else if (debug_interface_req) begin
      fixed_req.valid = 1'b1;
      fixed_req.level = `IVP_DBG_LVL;
      fixed_req.vector = `IVP_DBG_VEC;
    end
  end

  // External inputs: encoded levels or four separate pins
  always_comb begin
    mode = external_input_mode_select ? IVP_MODE_PINS : IVP_MODE_ENCODED;
    ext_req = '0;
    case (mode)
      IVP_MODE_ENCODED: begin
        // Level 0 means no request on the encoded inputs
        if (encoded_level_inputs != 4'h0) begin
          ext_req.valid = 1'b1;
          ext_req.ext = 1'b1;
          ext_req.level = {1'b0, encoded_level_inputs};
          ext_req.vector = `IVP_ENC_VEC_BASE +
            7'({4'h0, encoded_level_inputs[3:1]});
        end
      end
      IVP_MODE_PINS: begin
        // Pin 0 scanned last so it wins ties between pins
        for (int p = PIN_N - 1; p >= 0; p--) begin
          if (external_request_pins[p] &&
              prio_c_q[15 - p*4 -: 4] != 4'h0 &&
              (!ext_req.valid ||
               {1'b0, prio_c_q[15 - p*4 -: 4]} >= ext_req.level)) begin
            ext_req.valid = 1'b1;
            ext_req.ext = 1'b1;
            ext_req.level = {1'b0, prio_c_q[15 - p*4 -: 4]};
            ext_req.vector = `IVP_PIN_VEC_BASE + 7'(p);
          end
        end
      end
      default: begin
        ext_req = '0;
      end
    endcase
    // Caller guarantees the fetched vector fits in seven bits
    if (ext_req.valid && ext_vector_fetch_en) begin
      ext_req.vector = ext_vector;
    end
  end

  // Peripheral winner carries its software-set vector
  always_comb begin
    per_sel = '0;
    per_sel.valid = per_hit;
    per_sel.level = {1'b0, per_level};
    per_sel.vector = vec_field(vector_number_reg, per_idx);
  end

  // Fixed order among equal levels: fixed, external, then peripherals
  always_comb begin
    win = prefer(prefer(fixed_req, ext_req), per_sel);
    grant_d = '0;
    // Only the non-maskable level passes a full mask
    if (win.valid && win.level > {1'b0, core_mask_level}) begin
      grant_d.valid = 1'b1;
      grant_d.level = win.level;
      grant_d.vector = win.vector;
      grant_d.table_addr = table_addr(vector_base_register,
                                      win.vector);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      grant_q <= '0;
      prio_c_q <= `IVP_PRIO_C_RST;
      eth_event_q <= 1'b0;
    end else begin
      grant_q <= grant_d;
      prio_c_q <= prio_c_d;
      eth_event_q <= eth_event_d;
    end
  end

  // One cycle of pipeline keeps every output on a flop
  always_comb begin
    irq_valid_q = grant_q.valid;
    irq_level_q = grant_q.level;
    irq_vector_q = grant_q.vector;
    irq_table_addr_q = grant_q.table_addr;
    ethernet_dma_event_q = eth_event_q;
    priority_level_reg_c_q = prio_c_q;
  end

endmodule

// >>> verification/ivp_core_model.sv
// Far-side model supplying vectors during external fetch cycles
`timescale 1ns/10ps
module ivp_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic fetch_en,
  input wire logic [6:0] want,
  output logic [6:0] ext_vector
);
  logic [6:0] junk_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      junk_q <= 7'h2A;
    end else begin
      junk_q <= ~junk_q;
    end
  end
  // Outside a fetch the bus toggles, so a stale vector never looks valid
  assign ext_vector = fetch_en ? want : junk_q;
endmodule

// >>> verification/ivp_ctrl_props.sv
// Concurrent checks on the interrupt vectoring block ports
`timescale 1ns/10ps
module ivp_props
  import ivp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic nmi_req,
  input wire logic user_break_req,
  input wire logic debug_interface_req,
  input wire logic external_input_mode_select,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic prio_c_we,
  input wire logic [15:0] prio_c_wdata,
  input wire logic ext_vector_fetch_en,
  input wire logic [18:0] eth_dma_status_reg,
  input wire logic [18:0] eth_dma_status_enable_reg,
  input wire logic [2:0] mac_status_reg,
  input wire logic [2:0] mac_status_enable,
  input wire logic [31:0] vector_base_register,
  input wire logic [3:0] core_mask_level,
  input wire logic irq_valid_q,
  input wire logic [4:0] irq_level_q,
  input wire logic [6:0] irq_vector_q,
  input wire logic [31:0] irq_table_addr_q,
  input wire logic ethernet_dma_event_q,
  input wire logic [15:0] priority_level_reg_c_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic hi_quiet;
  assign hi_quiet = !nmi_req && !user_break_req && !debug_interface_req;
  sequence s_eth_set;
    |(eth_dma_status_reg & eth_dma_status_enable_reg);
  endsequence
  sequence s_eth_clear;
    !(|(eth_dma_status_reg & eth_dma_status_enable_reg))
      && !(|(mac_status_reg & mac_status_enable));
  endsequence
  a_table_addr: assert property (
    irq_valid_q |-> irq_table_addr_q ==
    $past(vector_base_register) + {irq_vector_q, 2'b00})
    else $error("table address wrong");
  a_nmi_vec: assert property (
    nmi_req |=> irq_vector_q == 7'h0B && irq_level_q == 5'h10)
    else $error("nmi vector wrong");
  a_break_vec: assert property (
    user_break_req && !nmi_req && core_mask_level != 4'hF
    |=> irq_vector_q == 7'h0C && irq_level_q == 5'h0F)
    else $error("break vector wrong");
  a_debug_vec: assert property (
    debug_interface_req && !nmi_req && !user_break_req
    && core_mask_level != 4'hF
    |=> irq_vector_q == 7'h0D && irq_level_q == 5'h0F)
    else $error("debug vector wrong");
  a_eth_event: assert property (
    s_eth_set |=> ethernet_dma_event_q) else $error("eth event missing");
  a_eth_quiet: assert property (
    s_eth_clear |=> !ethernet_dma_event_q) else $error("eth event stray");
  a_prio_write: assert property (
    prio_c_we |=> priority_level_reg_c_q == $past(prio_c_wdata))
    else $error("priority write lost");
  a_encoded_vec: assert property (
    !external_input_mode_select && encoded_level_inputs == 4'hF
    && hi_quiet && !ext_vector_fetch_en && core_mask_level != 4'hF
    |=> irq_vector_q == 7'h47 && irq_level_q == 5'h0F)
    else $error("encoded vector wrong");
  a_mask_gate: assert property (
    irq_valid_q |-> irq_level_q > {1'b0, $past(core_mask_level)})
    else $error("masked level passed");
endmodule
bind ivp_ctrl ivp_props u_props (.*);

// >>> verification/ivp_ctrl_tb.sv
// Self-checking bench for the interrupt vectoring block
`timescale 1ns/10ps
module ivp_ctrl_tb;
  import ivp_pkg::*;
  logic clk = 1'b0;
  logic nrst, nmi_req, user_break_req, debug_interface_req, prio_c_we;
  logic external_input_mode_select, ext_vector_fetch_en;
  logic [3:0] encoded_level_inputs, external_request_pins, core_mask_level;
  logic [15:0] prio_c_wdata, periph_req, priority_level_reg_c_q;
  logic [6:0] ext_vector, want_vec, irq_vector_q;
  logic [63:0] periph_level;
  logic [111:0] vector_number_reg;
  logic [18:0] eth_dma_status_reg, eth_dma_status_enable_reg;
  logic [2:0] mac_status_reg, mac_status_enable;
  logic [31:0] vector_base_register, irq_table_addr_q;
  logic irq_valid_q, ethernet_dma_event_q;
  logic [4:0] irq_level_q;
  int fails = 0;
  int checks = 0;
  always #2 clk = ~clk;
  ivp_ctrl uut (.*);
  ivp_core_model core (.clk, .nrst, .fetch_en(ext_vector_fetch_en),
    .want(want_vec), .ext_vector);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic look(input logic [4:0] lvl, input logic [6:0] vec);
    chk(irq_valid_q, lvl != 5'h00);
    chk(irq_level_q, lvl);
    chk(irq_vector_q, vec);
    chk(irq_table_addr_q, (lvl != 5'h00) ?
      vector_base_register + {vec, 2'b00} : 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #4000;
    fails++;
    give_verdict;
  end
  initial begin
    {nrst, nmi_req, user_break_req, debug_interface_req, prio_c_we} = '0;
    {external_input_mode_select, ext_vector_fetch_en, want_vec} = '0;
    {encoded_level_inputs, external_request_pins, core_mask_level} = '0;
    {prio_c_wdata, periph_req, periph_level, vector_number_reg} = '0;
    {eth_dma_status_reg, eth_dma_status_enable_reg} = '0;
    {mac_status_reg, mac_status_enable} = '0;
    vector_base_register = 32'h0001_0000;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    tick(1);
    look(5'h00, 7'h00);
    chk(priority_level_reg_c_q, 16'h0000);
    $display("reset done");
    @(posedge clk);
    {prio_c_we, external_input_mode_select} <= 2'b11;
    prio_c_wdata <= 16'h1234;
    external_request_pins <= 4'hF;
    tick(1);
    chk(priority_level_reg_c_q, 16'h1234);
    @(posedge clk);
    prio_c_wdata <= 16'h5555;
    tick(0);
    look(5'h04, 7'h43);
    @(posedge clk);
    prio_c_we <= 1'b0;
    tick(1);
    look(5'h05, 7'h40);
    @(posedge clk);
    {ext_vector_fetch_en, want_vec} <= 8'hFF;
    tick(1);
    look(5'h05, 7'h7F);
    @(posedge clk);
    ext_vector_fetch_en <= 1'b0;
    core_mask_level <= 4'h5;
    tick(1);
    look(5'h00, 7'h00);
    $display("pins done");
    @(posedge clk);
    {external_input_mode_select, core_mask_level} <= '0;
    encoded_level_inputs <= 4'hF;
    vector_base_register <= 32'h0002_0000;
    tick(1);
    look(5'h0F, 7'h47);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {nmi_req, user_break_req, debug_interface_req} <= 3'b111 >> i;
      tick(1);
      look(i == 0 ? 5'h10 : 5'h0F, 7'h0B + 7'(i));
    end
    $display("fixed sources done");
    @(posedge clk);
    {encoded_level_inputs, debug_interface_req} <= '0;
    periph_req <= 16'h0009;
    periph_level <= 64'h900F;
    vector_number_reg <= (112'h55 << 21) | 112'h22;
    tick(1);
    look(5'h09, 7'h55);
    @(posedge clk);
    {eth_dma_status_reg, eth_dma_status_enable_reg} <= {19'h20, 19'h20};
    tick(2);
    chk(ethernet_dma_event_q, 1'b1);
    look(5'h0F, 7'h22);
    @(posedge clk);
    eth_dma_status_enable_reg <= 19'h1;
    {mac_status_reg, mac_status_enable} <= 6'h12;
    tick(2);
    chk(ethernet_dma_event_q, 1'b1);
    @(posedge clk);
    mac_status_enable <= 3'h0;
    tick(2);
    chk(ethernet_dma_event_q, 1'b0);
    look(5'h09, 7'h55);
    $display("peripherals done");
    @(posedge clk);
    nrst <= 1'b0;
    tick(1);
    look(5'h00, 7'h00);
    chk(priority_level_reg_c_q, 16'h0000);
    $display("second reset done");
    give_verdict;
  end
endmodule
